/* File: actm_timer.v */
// Audio capable 10-bit timer: compare, timer and PWM modes with register port
`timescale 1ns/1ps
`default_nettype none
`include "actm_consts.vh"

module actm_timer (
   input  wire                   ref_clk_i,
   input  wire                   rst_i,
   input  wire [`ACTM_ADDR_W-1:0] addr_i,
   input  wire [7:0]             wdata_i,
   input  wire                   wr_i,
   input  wire                   rd_i,
   output reg  [7:0]             rdata_o,
   output reg                    primary_output_o,
   output reg                    primary_output_oe_o,
   output reg                    complement_output_o,
   output reg                    complement_output_oe_o,
   output reg                    audio_output_one_o,
   output reg                    audio_output_one_oe_o,
   output reg                    audio_output_two_o,
   output reg                    audio_output_two_oe_o
);

   ////////////////////////////////////////////////////////////////////////
   // Control and data storage

   reg                   counter_run_bit;
   reg                   audio_pwm_select;
   reg [1:0]             operating_mode_field;
   reg [1:0]             pin_action_field;
   reg                   output_level_bit;
   reg                   output_invert_bit;
   reg                   period_duty_swap;
   reg                   clear_source_select;
   reg [`ACTM_CNT_W-1:0] count;
   reg [`ACTM_CNT_W-1:0] soft_a;
   reg [`ACTM_CNT_W-1:0] soft_b;
   reg [7:0]             soft_p;
   reg [`ACTM_CNT_W-1:0] compare_a_value;
   reg [`ACTM_CNT_W-1:0] compare_b_value;
   reg [7:0]             period_value;
   reg                   match_a_flag;
   reg                   match_b_flag;
   reg                   match_period_flag;
   reg                   run_q;
   reg                   cmp_pin;

   ////////////////////////////////////////////////////////////////////////
   // Mode decode

   wire mode_cmp = (operating_mode_field == `ACTM_MODE_CMP);
   wire mode_pwm = (operating_mode_field == `ACTM_MODE_PWM);
   // Timer mode and the undefined code both leave the pins free
   wire mode_tmr = ~mode_cmp & ~mode_pwm;
   wire audio    = mode_pwm & audio_pwm_select;
   // Swap has no meaning in audio mode
   wire swap_eff = period_duty_swap & ~audio;
   wire run_rise = counter_run_bit & ~run_q;

   ////////////////////////////////////////////////////////////////////////
   // Comparators, all against the value the counter is about to take

   wire [`ACTM_CNT_W-1:0] next_inc = count + 1'b1;
   wire hit_a = (next_inc == compare_a_value);
   wire hit_b = (next_inc == compare_b_value);
   // Period zero matches at the 3FF wrap, so overflow needs no extra term
   wire hit_p = (next_inc[`ACTM_CNT_W-1:`ACTM_PER_LSB] == period_value) &&
                (next_inc[`ACTM_PER_LSB-1:0] == 2'h0);
   wire a_zero = (compare_a_value == `ACTM_CNT_ZERO);
   wire b_zero = (compare_b_value == `ACTM_CNT_ZERO);

   // Clear source per mode
   reg clr_hit;
   always @* begin
      if (mode_pwm) begin
         // Clear-select ignored; swap picks the period comparator
         clr_hit = swap_eff ? hit_a : hit_p;
      end else begin
         clr_hit = clear_source_select ? hit_a : hit_p;
      end
   end

   // Match events while running
   wire ev_a = counter_run_bit & hit_a & ~a_zero;
   // In compare and timer modes clear on A suppresses the period flag
   wire ev_p = counter_run_bit & hit_p &
               (mode_pwm | ~clear_source_select);
   // B comparator only reports in audio mode
   wire ev_b = counter_run_bit & hit_b & ~b_zero & audio;

   wire [`ACTM_CNT_W-1:0] next_count = ~counter_run_bit ? `ACTM_CNT_ZERO :
                                       clr_hit ? `ACTM_CNT_ZERO : next_inc;

   ////////////////////////////////////////////////////////////////////////
   // Duty values; zero period value means the full 1024 count

   wire [`ACTM_DUTY_W-1:0] per_duty = (period_value == `ACTM_BYTE_ZERO) ?
                                      `ACTM_FULL_DUTY : {1'b0, period_value, 2'h0};
   wire [`ACTM_DUTY_W-1:0] duty_a = {1'b0, compare_a_value};
   wire [`ACTM_DUTY_W-1:0] duty_b = {1'b0, compare_b_value};
   // Normal mode duty comes from the non-period register
   wire [`ACTM_DUTY_W-1:0] duty_norm = swap_eff ? per_duty : duty_a;

   wire [`ACTM_DUTY_W-1:0] duty_sel [0:1];
   assign duty_sel[0] = audio ? duty_a : duty_norm;
   assign duty_sel[1] = duty_b;

   wire [1:0] wave;

   // One shaper per output channel, fed with the next count value
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_chan
         actm_chan u_chan (
            .count_i      (next_count),
            .duty_i       (duty_sel[gi]),
            .pin_action_i (pin_action_field),
            .level_i      (output_level_bit),
            .invert_i     (output_invert_bit),
            .wave_o       (wave[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Register writes and shadow loading

   wire wr_ctl1  = wr_i & (addr_i == `ACTM_A_CTRL_FIRST);
   wire wr_ctl2  = wr_i & (addr_i == `ACTM_A_CTRL_SECOND);
   wire wr_al    = wr_i & (addr_i == `ACTM_A_CMPA_LO);
   wire wr_ah    = wr_i & (addr_i == `ACTM_A_CMPA_HI);
   wire wr_bl    = wr_i & (addr_i == `ACTM_A_CMPB_LO);
   wire wr_bh    = wr_i & (addr_i == `ACTM_A_CMPB_HI);
   wire wr_per   = wr_i & (addr_i == `ACTM_A_PERIOD);
   wire wr_flags = wr_i & (addr_i == `ACTM_A_FLAGS);

   // Active copies follow writes one cycle later except in audio mode
   wire load_act = ~audio | ev_p;

   // Software visible control bits
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         counter_run_bit      <= 1'b0;
         audio_pwm_select     <= 1'b0;
         operating_mode_field <= `ACTM_MODE_CMP;
         pin_action_field     <= `ACTM_PIN_NONE;
         output_level_bit     <= 1'b0;
         output_invert_bit    <= 1'b0;
         period_duty_swap     <= 1'b0;
         clear_source_select  <= 1'b0;
      end else begin
         if (wr_ctl1) begin
            counter_run_bit  <= wdata_i[`ACTM_B_RUN];
            audio_pwm_select <= wdata_i[`ACTM_B_AUDIO];
         end
         if (wr_ctl2) begin
            operating_mode_field <= wdata_i[`ACTM_F_MODE_HI:`ACTM_F_MODE_LO];
            pin_action_field     <= wdata_i[`ACTM_F_PIN_HI:`ACTM_F_PIN_LO];
            output_level_bit     <= wdata_i[`ACTM_B_LEVEL];
            output_invert_bit    <= wdata_i[`ACTM_B_INVERT];
            clear_source_select  <= wdata_i[`ACTM_B_CLRSEL];
         end
         // Hardware holds the swap bit low while audio mode is on
         if (audio) begin
            period_duty_swap <= 1'b0;
         end else if (wr_ctl2) begin
            period_duty_swap <= wdata_i[`ACTM_B_SWAP];
         end
      end
   end

   // Software copies of the compare values, byte at a time
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         soft_a <= `ACTM_CNT_ZERO;
         soft_b <= `ACTM_CNT_ZERO;
         soft_p <= `ACTM_BYTE_ZERO;
      end else begin
         if (wr_al) begin
            soft_a[7:0] <= wdata_i;
         end
         if (wr_ah) begin
            soft_a[9:8] <= wdata_i[1:0];
         end
         if (wr_bl) begin
            soft_b[7:0] <= wdata_i;
         end
         if (wr_bh) begin
            soft_b[9:8] <= wdata_i[1:0];
         end
         if (wr_per) begin
            soft_p <= wdata_i;
         end
      end
   end

   // Working values; the one-cycle lag outside audio mode is harmless
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         compare_a_value <= `ACTM_CNT_ZERO;
         compare_b_value <= `ACTM_CNT_ZERO;
         period_value    <= `ACTM_BYTE_ZERO;
      end else if (load_act) begin
         compare_a_value <= soft_a;
         compare_b_value <= soft_b;
         period_value    <= soft_p;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Counter and sticky flags; a new event wins over a clear

   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         count             <= `ACTM_CNT_ZERO;
         run_q             <= 1'b0;
         match_a_flag      <= 1'b0;
         match_b_flag      <= 1'b0;
         match_period_flag <= 1'b0;
      end else begin
         count <= next_count;
         run_q <= counter_run_bit;
         if (ev_a) begin
            match_a_flag <= 1'b1;
         end else if (wr_flags & wdata_i[`ACTM_B_FLAG_A]) begin
            match_a_flag <= 1'b0;
         end
         if (ev_p) begin
            match_period_flag <= 1'b1;
         end else if (wr_flags & wdata_i[`ACTM_B_FLAG_P]) begin
            match_period_flag <= 1'b0;
         end
         if (ev_b) begin
            match_b_flag <= 1'b1;
         end else if (wr_flags & wdata_i[`ACTM_B_FLAG_B]) begin
            match_b_flag <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Compare mode pin state

   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         cmp_pin <= 1'b0;
      end else if (run_rise) begin
         cmp_pin <= output_level_bit;
      end else if (ev_a & mode_cmp) begin
         // Only an A event moves the pin; period matches never do
         case (pin_action_field)
            `ACTM_PIN_LOW:    cmp_pin <= 1'b0;
            `ACTM_PIN_HIGH:   cmp_pin <= 1'b1;
            `ACTM_PIN_TOGGLE: cmp_pin <= ~cmp_pin;
            default:          cmp_pin <= cmp_pin;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output pins, each from its own flop

   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         primary_output_o       <= 1'b0;
         primary_output_oe_o    <= 1'b0;
         complement_output_o    <= 1'b0;
         complement_output_oe_o <= 1'b0;
         audio_output_one_o     <= 1'b0;
         audio_output_one_oe_o  <= 1'b0;
         audio_output_two_o     <= 1'b0;
         audio_output_two_oe_o  <= 1'b0;
      end else begin
         // Pin released in timer mode so it can serve other functions
         primary_output_oe_o    <= ~mode_tmr & ~audio;
         complement_output_oe_o <= mode_pwm & ~audio;
         audio_output_one_oe_o  <= audio;
         audio_output_two_oe_o  <= audio;
         if (mode_pwm) begin
            primary_output_o <= wave[0];
         end else begin
            primary_output_o <= cmp_pin ^ output_invert_bit;
         end
         complement_output_o <= ~wave[0];
         audio_output_one_o  <= wave[0];
         audio_output_two_o  <= wave[1];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read port: data valid only in the cycle after the strobe

   reg [7:0] rd_mux;
   always @* begin
      case (addr_i)
         `ACTM_A_CTRL_FIRST:  rd_mux = {6'h00, audio_pwm_select, counter_run_bit};
         `ACTM_A_CTRL_SECOND: rd_mux = {operating_mode_field, pin_action_field,
                                        output_level_bit, output_invert_bit,
                                        period_duty_swap, clear_source_select};
         `ACTM_A_COUNT_LO:    rd_mux = count[7:0];
         `ACTM_A_COUNT_HI:    rd_mux = {6'h00, count[9:8]};
         `ACTM_A_CMPA_LO:     rd_mux = soft_a[7:0];
         `ACTM_A_CMPA_HI:     rd_mux = {6'h00, soft_a[9:8]};
         `ACTM_A_CMPB_LO:     rd_mux = soft_b[7:0];
         `ACTM_A_CMPB_HI:     rd_mux = {6'h00, soft_b[9:8]};
         `ACTM_A_PERIOD:      rd_mux = soft_p;
         `ACTM_A_FLAGS:       rd_mux = {5'h00, match_b_flag, match_period_flag,
                                        match_a_flag};
         default:             rd_mux = `ACTM_BYTE_ZERO;
      endcase
   end

   // Read data return to zero outside the answer cycle
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         rdata_o <= `ACTM_BYTE_ZERO;
      end else if (rd_i) begin
         rdata_o <= rd_mux;
      end else begin
         rdata_o <= `ACTM_BYTE_ZERO;
      end
   end

endmodule
`default_nettype wire

/* File: actm_consts.vh */
// Constants for the audio capable timer: register map, field positions, codes
`ifndef ACTM_CONSTS_VH
`define ACTM_CONSTS_VH

// Register addresses on the plain register port
`define ACTM_ADDR_W        4
`define ACTM_A_CTRL_FIRST  4'h0
`define ACTM_A_CTRL_SECOND 4'h1
`define ACTM_A_COUNT_LO    4'h2
`define ACTM_A_COUNT_HI    4'h3
`define ACTM_A_CMPA_LO     4'h4
`define ACTM_A_CMPA_HI     4'h5
`define ACTM_A_CMPB_LO     4'h6
`define ACTM_A_CMPB_HI     4'h7
`define ACTM_A_PERIOD      4'h8
`define ACTM_A_FLAGS       4'h9

// First control register fields
`define ACTM_B_RUN         0
`define ACTM_B_AUDIO       1

// Second control register fields
`define ACTM_F_MODE_HI     7
`define ACTM_F_MODE_LO     6
`define ACTM_F_PIN_HI      5
`define ACTM_F_PIN_LO      4
`define ACTM_B_LEVEL       3
`define ACTM_B_INVERT      2
`define ACTM_B_SWAP        1
`define ACTM_B_CLRSEL      0

// Flag register fields, write one to clear
`define ACTM_B_FLAG_A      0
`define ACTM_B_FLAG_P      1
`define ACTM_B_FLAG_B      2

// Operating mode codes
`define ACTM_MODE_CMP      2'h0
`define ACTM_MODE_PWM      2'h2
`define ACTM_MODE_TMR      2'h3

// Pin action codes, compare mode
`define ACTM_PIN_NONE      2'h0
`define ACTM_PIN_LOW       2'h1
`define ACTM_PIN_HIGH      2'h2
`define ACTM_PIN_TOGGLE    2'h3

// Pin action codes, PWM mode
`define ACTM_PWM_INACT     2'h0
`define ACTM_PWM_ACT       2'h1
`define ACTM_PWM_WAVE      2'h2

// Widths and reset values
`define ACTM_CNT_W         10
`define ACTM_DUTY_W        11
`define ACTM_FULL_DUTY     11'h400
`define ACTM_CNT_ZERO      10'h000
`define ACTM_BYTE_ZERO     8'h00
`define ACTM_PER_LSB       2

`endif

/* File: actm_chan.v */
// One PWM channel: duty compare and pin level shaping
`timescale 1ns/1ps
`default_nettype none
`include "actm_consts.vh"

module actm_chan (
   input  wire [`ACTM_CNT_W-1:0]  count_i,
   input  wire [`ACTM_DUTY_W-1:0] duty_i,
   input  wire [1:0]              pin_action_i,
   input  wire                    level_i,
   input  wire                    invert_i,
   output reg                     wave_o
);

   reg active;

   // Active from the period start until the duty match
   always @* begin
      active = ({1'b0, count_i} < duty_i);
      case (pin_action_i)
         `ACTM_PWM_INACT: active = 1'b0;
         `ACTM_PWM_ACT:   active = 1'b1;
         `ACTM_PWM_WAVE:  active = active;
         default:         active = 1'b0; // Undefined code held inactive
      endcase
      // Active level chooses high or low, invert flips the result
      wave_o = (active ? level_i : ~level_i) ^ invert_i;
   end

endmodule
`default_nettype wire

/* File: actm_properties.sv */
// Port-level assertions for the audio capable timer
`timescale 1ns/1ps
`default_nettype none
`include "actm_consts.vh"
module actm_properties (
   input wire logic       ref_clk_i,
   input wire logic       rst_i,
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic       wr_i,
   input wire logic       rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic       primary_output_o,
   input wire logic       primary_output_oe_o,
   input wire logic       complement_output_o,
   input wire logic       complement_output_oe_o,
   input wire logic       audio_output_one_o,
   input wire logic       audio_output_one_oe_o,
   input wire logic       audio_output_two_o,
   input wire logic       audio_output_two_oe_o
);
   logic [7:0] ctl;
   logic       run;
   logic       aud;
   logic       rd_hi;
   logic       rd_fl;
   wire        pwm = ctl[7:6] == `ACTM_MODE_PWM;
   wire        act = ctl[3] ^ ctl[2];
   ////////////////////////////////////////////////////////////////
   // Shadow of the control bits, taken from the bus writes
   always_ff @(posedge ref_clk_i) begin
      rd_hi <= rd_i && addr_i == `ACTM_A_COUNT_HI;
      rd_fl <= rd_i && addr_i == `ACTM_A_FLAGS;
      if (rst_i) begin
         ctl <= 8'h00;
         run <= 1'b0;
         aud <= 1'b0;
      end else if (wr_i && addr_i == `ACTM_A_CTRL_SECOND) begin
         ctl <= wdata_i;
      end else if (wr_i && addr_i == `ACTM_A_CTRL_FIRST) begin
         run <= wdata_i[`ACTM_B_RUN];
         aud <= wdata_i[`ACTM_B_AUDIO];
      end
   end
   ////////////////////////////////////////////////////////////////
   // Antecedents wait three cycles so the registered pins have settled
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   a_tmr_release: assert property ((ctl[7:6] == `ACTM_MODE_TMR && run)[*3] |->
      !primary_output_oe_o && !complement_output_oe_o) else $error("pin driven in timer mode");
   a_normal_pins: assert property ((pwm && !aud && run)[*3] |->
      primary_output_oe_o && complement_output_oe_o && !audio_output_one_oe_o)
      else $error("normal pwm pins wrong");
   a_audio_pins: assert property ((pwm && aud && run)[*3] |->
      audio_output_one_oe_o && audio_output_two_oe_o && !primary_output_oe_o)
      else $error("audio pwm pins wrong");
   a_comp_inverse: assert property (complement_output_oe_o |->
      complement_output_o != primary_output_o) else $error("complement not inverse");
   a_force_active: assert property (
      (pwm && !aud && run && ctl[5:4] == `ACTM_PWM_ACT)[*3] |-> primary_output_o == act)
      else $error("forced active level wrong");
   a_force_idle: assert property (
      (pwm && !aud && run && ctl[5:4] == `ACTM_PWM_INACT)[*3] |-> primary_output_o == !act)
      else $error("forced inactive level wrong");
   a_count_width: assert property (rd_hi |-> rdata_o[7:2] == 6'h00)
      else $error("counter wider than ten bits");
   a_run_level: assert property ($rose(run) && ctl[7:6] == `ACTM_MODE_CMP &&
      ctl[5:4] == `ACTM_PIN_NONE |-> ##3 (primary_output_o == act)[*4])
      else $error("initial level not loaded");
   c_cmp_start: cover property ($rose(run) && ctl[7:6] == `ACTM_MODE_CMP);
   c_audio_on: cover property (pwm && aud && audio_output_two_o);
   c_flag_b: cover property (rd_fl && rdata_o[`ACTM_B_FLAG_B]);
endmodule
`default_nettype wire

/* File: actm_load.sv */
// Load model on one output pin: high time, rising edges, last pulse length
`timescale 1ns/1ps
`default_nettype none
module actm_load (
   input  wire logic        clk_i,
   input  wire logic        clr_i,
   input  wire logic        pin_i,
   input  wire logic        oe_i,
   output var  logic [10:0] high_cnt_o,
   output var  logic [3:0]  rise_cnt_o,
   output var  logic [10:0] last_len_o
);
   logic [10:0] run_len;
   logic        lvl_q;
   // A released pin is silent: the load cannot hear a level nobody drives
   wire         lvl = pin_i & oe_i;
   always @(posedge clk_i) begin
      lvl_q <= lvl;
      if (clr_i) begin
         high_cnt_o <= 11'h000;
         rise_cnt_o <= 4'h0;
         run_len <= 11'h000;
         last_len_o <= 11'h000;
      end else if (lvl) begin
         high_cnt_o <= high_cnt_o + 11'h001;
         run_len <= run_len + 11'h001;
         rise_cnt_o <= rise_cnt_o + {3'h0, !lvl_q};
      end else if (run_len != 11'h000) begin
         last_len_o <= run_len;
         run_len <= 11'h000;
      end
   end
endmodule
`default_nettype wire

/* File: audio_capable_timer_modes_tb_top.sv */
// Self-checking bench for the audio capable timer
`timescale 1ns/1ps
`default_nettype none
`include "actm_consts.vh"
module audio_capable_timer_modes_tb_top;
   logic        ref_clk_i, rst_i, wr_i, rd_i, clr;
   logic [3:0]  addr_i;
   logic [7:0]  wdata_i;
   wire  [7:0]  rdata_o;
   wire         p_o, p_oe, c_o, c_oe, a1, a1_oe, a2, a2_oe;
   wire  [3:0]  pins = {a2, a1, c_o, p_o};
   wire  [3:0]  oes = {a2_oe, a1_oe, c_oe, p_oe};
   wire  [10:0] hi [0:3];
   wire  [3:0]  rs [0:3];
   wire  [10:0] ln [0:3];
   int          error_cnt, checked;
   actm_timer dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .primary_output_o(p_o),
      .primary_output_oe_o(p_oe), .complement_output_o(c_o), .complement_output_oe_o(c_oe),
      .audio_output_one_o(a1), .audio_output_one_oe_o(a1_oe), .audio_output_two_o(a2),
      .audio_output_two_oe_o(a2_oe));
   // Loads: 0 primary, 1 complement, 2 and 3 the audio pair
   for (genvar g = 0; g < 4; g++) begin : g_ld
      actm_load u_ld (.clk_i(ref_clk_i), .clr_i(clr), .pin_i(pins[g]), .oe_i(oes[g]),
         .high_cnt_o(hi[g]), .rise_cnt_o(rs[g]), .last_len_o(ln[g]));
   end
   ////////////////////////////////////////////////////////////////
   task automatic chk(input logic [10:0] got, input logic [10:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic stop_test;
      $display("errors %0d checks %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
      @(posedge ref_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
      @(negedge ref_clk_i);
      chk({3'h0, rdata_o}, {3'h0, exp});
   endtask
   // Stop first: mode and pin fields must not change while counting
   task automatic setup(input logic [7:0] c2, input logic [9:0] ca, input logic [7:0] p,
                        input logic au);
      wr(`ACTM_A_CTRL_FIRST, 8'h00);
      wr(`ACTM_A_CTRL_SECOND, c2);
      wr(`ACTM_A_CMPA_LO, ca[7:0]);
      wr(`ACTM_A_CMPA_HI, {6'h00, ca[9:8]});
      wr(`ACTM_A_PERIOD, p);
      wr(`ACTM_A_FLAGS, 8'h07);
      wr(`ACTM_A_CTRL_FIRST, {6'h00, au, 1'b1});
   endtask
   task automatic measure(input logic [10:0] win);
      @(posedge ref_clk_i);
      clr <= 1'b1;
      @(posedge ref_clk_i);
      clr <= 1'b0;
      repeat (win) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
   endtask
   ////////////////////////////////////////////////////////////////
   task automatic t_regs;
      rdc(`ACTM_A_CTRL_SECOND, 8'h00);
      wr(`ACTM_A_CMPA_HI, 8'hFF);
      rdc(`ACTM_A_CMPA_HI, 8'h03);
      wr(`ACTM_A_PERIOD, 8'hA5);
      rdc(`ACTM_A_PERIOD, 8'hA5);
      wr(4'hF, 8'hFF);
      rdc(4'hF, 8'h00);
   endtask
   // Duty values stay below the period throughout
   task automatic t_pwm;
      logic [7:0]  c2 [8] = '{8'hA8, 8'hA9, 8'hA0, 8'hAC, 8'hAA, 8'h98, 8'h88, 8'hA8};
      logic [9:0]  ca [8] = '{10'h003, 10'h003, 10'h003, 10'h003, 10'h00A, 10'h003, 10'h003,
                              10'h064};
      logic [7:0]  pr [8] = '{8'h02, 8'h02, 8'h02, 8'h02, 8'h01, 8'h02, 8'h02, 8'h00};
      logic [10:0] wn [8] = '{11'h020, 11'h020, 11'h020, 11'h020, 11'h01E, 11'h020, 11'h020,
                              11'h400};
      logic [10:0] he [8] = '{11'h00C, 11'h00C, 11'h014, 11'h014, 11'h00C, 11'h020, 11'h000,
                              11'h064};
      for (int i = 0; i < 8; i++) begin
         setup(c2[i], ca[i], pr[i], 1'b0);
         repeat (8) @(posedge ref_clk_i);
         measure(wn[i]);
         chk(hi[0], he[i]);
         chk(hi[1], wn[i] - he[i]);
         rdc(`ACTM_A_FLAGS, 8'h03);
      end
   endtask
   // The first A match falls inside the window: driving high from a low start is one rise
   task automatic t_cmp;
      logic [7:0] c2 [4] = '{8'h08, 8'h18, 8'h20, 8'h38};
      logic [3:0] re [4] = '{4'h0, 4'h0, 4'h1, 4'h2};
      logic       fe [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
      for (int i = 0; i < 4; i++) begin
         setup(c2[i], 10'h005, 8'h03, 1'b0);
         repeat (3) @(posedge ref_clk_i);
         @(negedge ref_clk_i);
         chk(p_o, c2[i][3]);
         measure(11'h030);
         chk(rs[0], re[i]);
         chk(p_o, fe[i]);
      end
   endtask
   task automatic t_flags;
      logic [7:0] c2 [4] = '{8'h21, 8'h20, 8'hE0, 8'h20};
      logic [9:0] ca [4] = '{10'h005, 10'h005, 10'h005, 10'h000};
      logic [7:0] pr [4] = '{8'h01, 8'h03, 8'h03, 8'h00};
      logic [7:0] fe [4] = '{8'h01, 8'h03, 8'h03, 8'h02};
      logic       oe [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
      for (int i = 0; i < 4; i++) begin
         setup(c2[i], ca[i], pr[i], 1'b0);
         repeat (1100) @(posedge ref_clk_i);
         rdc(`ACTM_A_FLAGS, fe[i]);
         chk(p_oe, oe[i]);
         // Free running since the run write: 1103 edges wrap once past 3FF to 4F
         if (i == 3) begin
            rdc(`ACTM_A_COUNT_LO, 8'h4F);
            rdc(`ACTM_A_COUNT_HI, 8'h00);
         end
      end
   endtask
   // Swap bit written high on purpose: audio mode must ignore it
   task automatic t_audio;
      int   n;
      logic pv;
      wr(`ACTM_A_CMPB_LO, 8'h05);
      setup(8'hAA, 10'h003, 8'h02, 1'b1);
      repeat (8) @(posedge ref_clk_i);
      measure(11'h020);
      chk(hi[2], 11'h00C);
      chk(hi[3], 11'h014);
      rdc(`ACTM_A_FLAGS, 8'h07);
      // Swap was written high; hardware must have cleared it
      rdc(`ACTM_A_CTRL_SECOND, 8'hA8);
      pv = 1'b1;
      for (n = 0; n < 20 && !(pv === 1'b0 && a1 === 1'b1); n++) begin
         pv = a1;
         @(negedge ref_clk_i);
      end
      // Bounded hunt for a period start; running out is a mismatch
      if (n == 20) begin
         error_cnt++;
         $display("unexpected at %0t: no audio period start found", $time);
         return;
      end
      wr(`ACTM_A_CMPA_LO, 8'h06);
      repeat (8) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      chk(ln[2], 11'h003);
      repeat (8) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      chk(ln[2], 11'h006);
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      ref_clk_i = 1'b0;
      forever #20 ref_clk_i = ~ref_clk_i;
   end
   initial begin
      rst_i = 1'b1;
      wr_i = 1'b0;
      rd_i = 1'b0;
      clr = 1'b0;
      addr_i = 4'h0;
      wdata_i = 8'h00;
      error_cnt = 0;
      checked = 0;
      repeat (16) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_pwm();
      t_cmp();
      t_flags();
      t_audio();
      stop_test();
   end
endmodule
bind actm_timer actm_properties u_props (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
   .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .primary_output_o(primary_output_o), .primary_output_oe_o(primary_output_oe_o),
   .complement_output_o(complement_output_o), .complement_output_oe_o(complement_output_oe_o),
   .audio_output_one_o(audio_output_one_o), .audio_output_one_oe_o(audio_output_one_oe_o),
   .audio_output_two_o(audio_output_two_o), .audio_output_two_oe_o(audio_output_two_oe_o));
`default_nettype wire
